//--- rtl/dsl_cmd_decoder.sv
`timescale 1ns/1ns
`default_nettype none
`include "dsl_cfg.svh"
module dsl_cmd_decoder (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire dsl_pkg::dsl_req_s req,
	output logic rsp_valid_q,
	output dsl_pkg::dsl_rsp_s rsp_q,
	input wire logic [15:0] out_freq,
	input wire logic [15:0] out_curr,
	input wire logic [15:0] out_volt,
	input wire logic [15:0] spec_mon_data,
	input wire logic [15:0] status_word,
	input wire logic [15:0] chk_interval,
	input wire logic external_reset_input,
	input wire logic flt_wr_en,
	input wire logic [2:0] flt_wr_addr,
	input wire logic [15:0] flt_wr_data,
	output logic [15:0] op_mode_q,
	output logic [7:0] mon_sel_q,
	output logic [15:0] run_cmd_q,
	output logic forward_run_command_q,
	output logic reverse_run_command_q,
	output logic output_enable_q,
	output logic link_loss_fault_trip_q
);
	dsl_pkg::dsl_state_e state_q;
	dsl_pkg::dsl_state_e state_d;
	dsl_pkg::dsl_req_s req_q;
	logic [15:0] flt_rd;
	logic [31:0] tick_cnt_q;
	logic [15:0] chk_cnt_q;
	logic ext_rst_m_q;
	logic ext_rst_q;
	logic chk_armed_q;

	// ---------------------------------------------
	// fault history store
	// ---------------------------------------------
	logic [2:0] flt_idx;
	assign flt_idx = 3'(req_q.icode - `DSL_IC_FLT_FIRST);
	dsl_fault_mem u_flt (
		.core_clk(core_clk),
		.wr_en(flt_wr_en),
		.wr_addr(flt_wr_addr),
		.wr_data(flt_wr_data),
		.rd_addr(flt_idx),
		.rd_data_q(flt_rd)
	);

	// ---------------------------------------------
	// request decode
	// ---------------------------------------------
	logic ic_fault;
	logic ic_read;
	logic ic_write;
	logic ic_known;
	logic ic_two_dig;
	logic mode_ok;
	logic range_ok;
	// fault history codes
	// the five codes are consecutive, so one compare pair covers them
	assign ic_fault = (req_q.icode >= `DSL_IC_FLT_FIRST) && (req_q.icode <= `DSL_IC_FLT_LAST);
	assign ic_read = ic_fault
		|| req_q.icode == `DSL_IC_MODE_RD || req_q.icode == `DSL_IC_FREQ_RD
		|| req_q.icode == `DSL_IC_CURR_RD || req_q.icode == `DSL_IC_VOLT_RD
		|| req_q.icode == `DSL_IC_SPEC_RD || req_q.icode == `DSL_IC_MSEL_RD
		|| req_q.icode == `DSL_IC_STSX_RD || req_q.icode == `DSL_IC_STS_RD
		|| req_q.icode == `DSL_IC_STSX2_RD;
	assign ic_write = req_q.icode == `DSL_IC_MODE_WR || req_q.icode == `DSL_IC_MSEL_WR
		|| req_q.icode == `DSL_IC_RUNX_WR || req_q.icode == `DSL_IC_RUN_WR
		|| req_q.icode == `DSL_IC_RUNX2_WR;
	assign ic_known = ic_read || ic_write;
	assign ic_two_dig = req_q.icode == `DSL_IC_MSEL_RD || req_q.icode == `DSL_IC_MSEL_WR
		|| req_q.icode == `DSL_IC_STS_RD || req_q.icode == `DSL_IC_RUN_WR;
	assign mode_ok = req_q.data == `DSL_MODE_NET || req_q.data == `DSL_MODE_EXT
		|| req_q.data == `DSL_MODE_PNL;
	// range check; two-digit writes must fit one byte
	assign range_ok = (req_q.icode == `DSL_IC_MODE_WR) ? mode_ok :
		(ic_two_dig ? (req_q.data[15:8] == 8'h00) : 1'b1);

	// ---------------------------------------------
	// read data select
	// ---------------------------------------------
	logic [15:0] rd_val;
	// status forms; the basic form is the low byte only
	assign rd_val = (req_q.icode == `DSL_IC_MODE_RD) ? op_mode_q :
		(req_q.icode == `DSL_IC_FREQ_RD) ? out_freq :
		(req_q.icode == `DSL_IC_CURR_RD) ? out_curr :
		(req_q.icode == `DSL_IC_VOLT_RD) ? out_volt :
		(req_q.icode == `DSL_IC_SPEC_RD) ? spec_mon_data :
		(req_q.icode == `DSL_IC_MSEL_RD) ? {8'h00, mon_sel_q} :
		(req_q.icode == `DSL_IC_STS_RD) ? {8'h00, status_word[7:0]} :
		(req_q.icode == `DSL_IC_STSX_RD || req_q.icode == `DSL_IC_STSX2_RD) ? status_word :
		ic_fault ? flt_rd : 16'h0000;

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction
	// four slices come from the generate loop, so this is a net
	wire logic [31:0] rd_ascii;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_hex
			// most significant digit lands in the top byte
			assign rd_ascii[gi*8 +: 8] = hex_char(rd_val[gi*4 +: 4]);
		end
	endgenerate

	// ---------------------------------------------
	// request sequencer
	// ---------------------------------------------
	// exec spends one cycle so the fault memory read has landed
	always_comb begin
		state_d = state_q;
		case (state_q)
			dsl_pkg::ST_IDLE: begin
				if (req_valid && !req.bad) begin
					state_d = dsl_pkg::ST_EXEC;
				end
			end
			dsl_pkg::ST_EXEC: begin
				state_d = dsl_pkg::ST_REPLY;
			end
			dsl_pkg::ST_REPLY: begin
				state_d = dsl_pkg::ST_IDLE;
			end
			default: begin
				state_d = dsl_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q <= dsl_pkg::ST_IDLE;
			req_q <= '0;
		end else begin
			state_q <= state_d;
			if (state_q == dsl_pkg::ST_IDLE && req_valid && !req.bad) begin
				req_q <= req;
			end
		end
	end

	logic do_exec;
	logic do_write;
	assign do_exec = (state_q == dsl_pkg::ST_REPLY);
	assign do_write = do_exec && ic_write && range_ok;

	// ---------------------------------------------
	// reply build
	// ---------------------------------------------
	dsl_pkg::dsl_rsp_s rsp_d;
	logic [3:0] rsp_err;
	logic [2:0] rsp_ndig;
	logic [31:0] rsp_ascii;
	logic err_code;
	logic err_range;
	assign err_code = !ic_known;
	assign err_range = ic_known && ic_write && !range_ok;
	// code error outranks range error; the drive output is untouched by both
	assign rsp_err = err_code ? `DSL_ERR_ICODE : (err_range ? `DSL_ERR_RANGE : `DSL_ERR_OK);
	// only good reads carry digits; writes and errors answer bare
	assign rsp_ndig = (ic_read && !err_code) ? (ic_two_dig ? 3'd2 : 3'd4) : 3'd0;
	// two-digit answers sit in the low half, upper characters zero
	assign rsp_ascii = (rsp_ndig == 3'd2) ? {16'h0000, rd_ascii[15:0]} :
		((rsp_ndig == 3'd4) ? rd_ascii : 32'h0000_0000);
	assign rsp_d = '{err: rsp_err, ndig: rsp_ndig, ascii: rsp_ascii};

	// reply only as the end of an accepted request
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rsp_valid_q <= 1'b0;
			rsp_q <= '0;
		end else begin
			rsp_valid_q <= do_exec;
			if (do_exec) begin
				rsp_q <= rsp_d;
			end
		end
	end

	// ---------------------------------------------
	// write targets
	// ---------------------------------------------
	// write strobes: mode, select, and two for the run word; range failures never reach them
	logic wr_mode;
	logic wr_sel;
	logic wr_runx;
	logic wr_run;
	assign wr_mode = do_write && req_q.icode == `DSL_IC_MODE_WR;
	assign wr_sel = do_write && req_q.icode == `DSL_IC_MSEL_WR;
	assign wr_runx = do_write
		&& (req_q.icode == `DSL_IC_RUNX_WR || req_q.icode == `DSL_IC_RUNX2_WR);
	assign wr_run = do_write && req_q.icode == `DSL_IC_RUN_WR;

	// targets hold until the next accepted write
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			op_mode_q <= `DSL_MODE_RST;
			mon_sel_q <= 8'h00;
			run_cmd_q <= 16'h0000;
			forward_run_command_q <= 1'b0;
			reverse_run_command_q <= 1'b0;
		end else begin
			if (wr_mode) begin
				op_mode_q <= req_q.data;
			end
			if (wr_sel) begin
				mon_sel_q <= req_q.data[7:0];
			end
			if (wr_runx) begin
				run_cmd_q <= req_q.data;
				forward_run_command_q <= req_q.data[1];
				reverse_run_command_q <= req_q.data[2];
			end else if (wr_run) begin
				run_cmd_q <= {8'h00, req_q.data[7:0]};
				forward_run_command_q <= req_q.data[1];
				reverse_run_command_q <= req_q.data[2];
			end
		end
	end

	// ---------------------------------------------
	// communication check timer
	// ---------------------------------------------
	// reset pin is asynchronous to us, two flops before use
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ext_rst_m_q <= 1'b0;
			ext_rst_q <= 1'b0;
		end else begin
			ext_rst_m_q <= external_reset_input;
			ext_rst_q <= ext_rst_m_q;
		end
	end

	logic chk_off;
	logic host_seen;
	logic tick;
	assign chk_off = (chk_interval == `DSL_CHK_OFF) || (chk_interval == 16'd0)
		|| (chk_interval > `DSL_CHK_MAX);
	// any frame, good or bad, shows the host is alive
	assign host_seen = req_valid;
	assign tick = (tick_cnt_q == 32'(`DSL_TICK_CYC - 1));

	// limitation: one tick is 0.1 s of core_clk, so an expiry needs a long run
	// interval in 0.1 s ticks, disable setting
	always_ff @(posedge core_clk) begin
		if (sys_rst || host_seen || chk_off || !chk_armed_q) begin
			tick_cnt_q <= 32'h0;
			chk_cnt_q <= 16'h0000;
		end else begin
			tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
			if (tick) begin
				chk_cnt_q <= chk_cnt_q + 16'h0001;
			end
		end
	end

	// expiry trips the output; only external reset or sys_rst clears it
	always_ff @(posedge core_clk) begin
		if (sys_rst || ext_rst_q) begin
			chk_armed_q <= 1'b0;
			link_loss_fault_trip_q <= 1'b0;
			output_enable_q <= 1'b1;
		end else begin
			if (host_seen) begin
				chk_armed_q <= 1'b1;
			end
			if (!chk_off && chk_armed_q && !host_seen && chk_cnt_q >= chk_interval) begin
				link_loss_fault_trip_q <= 1'b1;
				output_enable_q <= 1'b0;
			end
		end
	end
endmodule // dsl_cmd_decoder
`default_nettype wire

//--- rtl/dsl_cfg.svh
`ifndef DSL_CFG_SVH
`define DSL_CFG_SVH
// instruction codes
`define DSL_IC_MODE_RD 8'h7B
`define DSL_IC_MODE_WR 8'hFB
`define DSL_IC_FREQ_RD 8'h6F
`define DSL_IC_CURR_RD 8'h70
`define DSL_IC_VOLT_RD 8'h71
`define DSL_IC_SPEC_RD 8'h72
`define DSL_IC_MSEL_RD 8'h73
`define DSL_IC_MSEL_WR 8'hF3
`define DSL_IC_FLT_FIRST 8'h74
`define DSL_IC_FLT_LAST 8'h78
`define DSL_IC_RUNX_WR 8'hF9
`define DSL_IC_RUN_WR 8'hFA
`define DSL_IC_RUNX2_WR 8'hFE
`define DSL_IC_STSX_RD 8'h79
`define DSL_IC_STS_RD 8'h7A
`define DSL_IC_STSX2_RD 8'h7E
// mode values
`define DSL_MODE_NET 16'h0000
`define DSL_MODE_EXT 16'h0001
`define DSL_MODE_PNL 16'h0002
`define DSL_MODE_RST 16'h0000
// error reply codes
`define DSL_ERR_ICODE 4'hB
`define DSL_ERR_RANGE 4'hC
`define DSL_ERR_OK 4'hF
// check interval tick: 0.1 s in ns, at 4 ns period
`define DSL_TICK_NS 100000000
`define DSL_CLK_NS 4
`define DSL_TICK_CYC (`DSL_TICK_NS / `DSL_CLK_NS)
// interval setting in 0.1 s units: 1..9998, 16'hFFFF disables
`define DSL_CHK_MAX 16'd9998
`define DSL_CHK_OFF 16'hFFFF
`define DSL_CHK_RST 16'hFFFF
`endif

//--- rtl/dsl_pkg.sv
`default_nettype none
package dsl_pkg;
	// one parsed request from the frame layer
	typedef struct packed {
		logic [7:0] icode;
		logic [15:0] data;
		logic bad;
	} dsl_req_s;
	// reply to the frame layer
	typedef struct packed {
		logic [3:0] err;
		logic [2:0] ndig;
		logic [31:0] ascii;
	} dsl_rsp_s;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_REPLY = 2'b10
	} dsl_state_e;
endpackage
`default_nettype wire

//--- rtl/dsl_fault_mem.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------
// fault record store, registered read
// ---------------------------------------------
module dsl_fault_mem (
	input wire logic core_clk,
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input wire logic [15:0] wr_data,
	input wire logic [2:0] rd_addr,
	output logic [15:0] rd_data_q
);
	logic [15:0] mem [0:4];
	// write port, entries 0..4
	always_ff @(posedge core_clk) begin
		if (wr_en && wr_addr < 3'd5) begin
			mem[wr_addr] <= wr_data;
		end
	end
	// read data come from a register; out-of-range reads give zero
	always_ff @(posedge core_clk) begin
		rd_data_q <= (rd_addr < 3'd5) ? mem[rd_addr] : 16'h0000;
	end
endmodule // dsl_fault_mem
`default_nettype wire

//--- bench/dsl_cmd_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------
// decoder port checker
// ---------------------------------------------
module dsl_cmd_monitor (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire dsl_pkg::dsl_req_s req,
	input wire logic rsp_valid_q,
	input wire dsl_pkg::dsl_rsp_s rsp_q,
	input wire logic [15:0] op_mode_q,
	input wire logic [15:0] run_cmd_q,
	input wire logic forward_run_command_q,
	input wire logic reverse_run_command_q,
	input wire logic output_enable_q,
	input wire logic link_loss_fault_trip_q,
	input wire logic [15:0] chk_interval
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// a good frame taken, and a frame flagged bad
	sequence s_take;
		req_valid && !req.bad;
	endsequence
	sequence s_bad_frame;
		req_valid && req.bad;
	endsequence
	a_reply_after_take: assert property (rsp_valid_q |-> $past(req_valid && !req.bad, 3))
		else $error("reply without a good request three cycles earlier");
	a_bad_frame_dropped: assert property (s_bad_frame |-> ##3 !rsp_valid_q)
		else $error("bad frame produced a reply");
	a_reply_one_cycle: assert property (rsp_valid_q |=> !rsp_valid_q)
		else $error("reply strobe longer than one cycle");
	a_trip_output_off: assert property (link_loss_fault_trip_q |-> !output_enable_q)
		else $error("output on while link loss trip set");
	a_mode_in_range: assert property (op_mode_q <= 16'h0002)
		else $error("operating mode outside 0..2");
	a_run_bits_track: assert property (forward_run_command_q == run_cmd_q[1]
		&& reverse_run_command_q == run_cmd_q[2])
		else $error("run bits differ from run word");
	a_error_keeps_output: assert property (rsp_valid_q && rsp_q.err inside {4'hB, 4'hC}
		|-> output_enable_q || link_loss_fault_trip_q)
		else $error("error reply shut the output off");
	a_short_reply_upper: assert property (rsp_valid_q && rsp_q.ndig == 3'h2
		|-> rsp_q.ascii[31:16] == 16'h0000)
		else $error("two digit reply has upper characters");
	a_range_no_write: assert property (rsp_valid_q && rsp_q.err == 4'hC
		|-> $stable(op_mode_q) && $stable(run_cmd_q))
		else $error("range error changed a target");
	a_trip_needs_silence: assert property ($rose(link_loss_fault_trip_q) |-> $past(!req_valid))
		else $error("link loss trip set right after a request");
	a_trip_needs_interval: assert property ($rose(link_loss_fault_trip_q)
		|-> $past(chk_interval) inside {[16'd1:16'd9998]})
		else $error("link loss trip while the check was disabled");
	c_take: cover property (s_take ##3 rsp_valid_q);
endmodule // dsl_cmd_monitor
bind dsl_cmd_decoder dsl_cmd_monitor u_mon (.core_clk(core_clk), .sys_rst(sys_rst),
	.req_valid(req_valid), .req(req), .rsp_valid_q(rsp_valid_q), .rsp_q(rsp_q),
	.op_mode_q(op_mode_q), .run_cmd_q(run_cmd_q), .forward_run_command_q(forward_run_command_q),
	.reverse_run_command_q(reverse_run_command_q), .output_enable_q(output_enable_q),
	.link_loss_fault_trip_q(link_loss_fault_trip_q), .chk_interval(chk_interval));
`default_nettype wire

//--- bench/dsl_host.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------
// host side request source
// ---------------------------------------------
module dsl_host (
	input wire logic core_clk,
	output logic req_valid,
	output dsl_pkg::dsl_req_s req
);
	initial begin
		req_valid = 1'b0;
		req = '0;
	end
	// one-cycle request; fields inverted afterwards so stale data never looks valid
	task automatic send(input logic [7:0] ic, input logic [15:0] d, input logic b);
		@(posedge core_clk);
		req_valid <= 1'b1;
		req <= '{icode: ic, data: d, bad: b};
		@(posedge core_clk);
		req_valid <= 1'b0;
		req <= '{icode: ~ic, data: ~d, bad: ~b};
	endtask
endmodule // dsl_host
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic core_clk, sys_rst, ext_rst, flt_wr_en, rsp_valid_q, fwd, rev, oe, trip, req_valid;
	logic [2:0] flt_wr_addr;
	logic [15:0] flt_wr_data, freq, curr, volt, spec, sts, chk, op_mode_q, run_cmd_q;
	logic [7:0] mon_sel_q;
	dsl_pkg::dsl_req_s req;
	dsl_pkg::dsl_rsp_s rsp_q;
	int n_errors = 0, checks_done = 0, cyc = 0;
	logic [31:0] lfsr = 32'd71490;
	logic [15:0] m_mode = 16'h0000, m_run = 16'h0000;
	logic [7:0] m_sel = 8'h00;
	logic [15:0] m_flt [5];
	logic [7:0] codes [18] = '{8'h7B, 8'hFB, 8'h6F, 8'h70, 8'h71, 8'h72, 8'h73, 8'hF3, 8'h74,
		8'h75, 8'h76, 8'h77, 8'h78, 8'hF9, 8'hFA, 8'hFE, 8'h79, 8'h7A};
	dsl_host host (.core_clk(core_clk), .req_valid(req_valid), .req(req));
	dsl_cmd_decoder dut (.core_clk(core_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
		.rsp_valid_q(rsp_valid_q), .rsp_q(rsp_q), .out_freq(freq), .out_curr(curr),
		.out_volt(volt), .spec_mon_data(spec), .status_word(sts), .chk_interval(chk),
		.external_reset_input(ext_rst), .flt_wr_en(flt_wr_en), .flt_wr_addr(flt_wr_addr),
		.flt_wr_data(flt_wr_data), .op_mode_q(op_mode_q), .mon_sel_q(mon_sel_q),
		.run_cmd_q(run_cmd_q), .forward_run_command_q(fwd), .reverse_run_command_q(rev),
		.output_enable_q(oe), .link_loss_fault_trip_q(trip));
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[15:0];
	endfunction
	function automatic logic [31:0] hex4(input logic [15:0] v);
		logic [31:0] a;
		for (int i = 0; i < 4; i++) begin
			a[8*i +: 8] = (v[4*i +: 4] < 4'hA) ? 8'h30 + v[4*i +: 4] : 8'h37 + v[4*i +: 4];
		end
		return a;
	endfunction
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("errors=%0d checks=%0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 20000) begin
			n_errors++;
			stop_test();
		end
	end
	// send one request, model the answer, compare reply and write targets
	task automatic xfer(input logic [7:0] ic, input logic [15:0] d, input logic b);
		logic [3:0] e;
		logic [2:0] n;
		logic [15:0] v;
		logic [31:0] asc;
		bit got;
		e = 4'hF;
		n = 3'h4;
		v = 16'h0000;
		got = 0;
		case (ic)
			8'h7B: v = m_mode;
			8'h6F: v = freq; 8'h70: v = curr; 8'h71: v = volt; 8'h72: v = spec;
			8'h79, 8'h7E: v = sts;
			8'h7A: begin n = 3'h2; v = sts[7:0]; end
			8'h73: begin n = 3'h2; v = m_sel; end
			8'h74, 8'h75, 8'h76, 8'h77, 8'h78: v = m_flt[ic - 8'h74];
			8'hFB: begin n = 0; if (d > 2) e = 4'hC; else if (!b) m_mode = d; end
			8'hF3, 8'hFA: begin
				n = 0;
				if (d[15:8] != 0) e = 4'hC;
				else if (!b && ic == 8'hF3) m_sel = d[7:0];
				else if (!b) m_run = d;
			end
			8'hF9, 8'hFE: begin n = 0; if (!b) m_run = d; end
			default: e = 4'hB;
		endcase
		host.send(ic, d, b);
		for (int k = 0; k < 8 && !got; k++) begin
			@(posedge core_clk);
			#1;
			if (rsp_valid_q === 1'b1) got = 1;
		end
		check(got, !b);
		if (got) check(rsp_q.err, e);
		asc = hex4(v);
		if (n == 3'h2) asc[31:16] = 16'h0000;
		if (got && e == 4'hF && n != 0) check({rsp_q.ndig, rsp_q.ascii}, {n, asc});
		if (got && (e != 4'hF || n == 0)) check({rsp_q.ndig, rsp_q.ascii}, 35'h0);
		check({op_mode_q, mon_sel_q}, {m_mode, m_sel});
		check({run_cmd_q, fwd, rev, oe}, {m_run, m_run[1], m_run[2], 1'b1});
	endtask
	initial begin
		sys_rst = 1'b1; ext_rst = 1'b0; flt_wr_en = 1'b0; flt_wr_addr = 3'h0; flt_wr_data = 16'h0000;
		freq = 16'h0000; curr = 16'h0000; volt = 16'h0000; spec = 16'h0000; sts = 16'h0000; chk = 16'hFFFF;
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		#1;
		check({rsp_valid_q, op_mode_q, mon_sel_q, run_cmd_q, oe, trip}, {1'b0, 40'h0, 2'b10});
		for (int i = 0; i < 5; i++) begin
			m_flt[i] = rnd();
			@(posedge core_clk);
			flt_wr_en <= 1'b1;
			flt_wr_addr <= 3'(i);
			flt_wr_data <= m_flt[i];
		end
		@(posedge core_clk);
		flt_wr_en <= 1'b0; freq <= rnd(); curr <= rnd(); volt <= rnd(); spec <= rnd(); sts <= rnd();
		chk <= 16'h0001;
		foreach (codes[i]) xfer(codes[i], 16'h0000 | rnd() % 3, 1'b0);
		xfer(8'h7E, 16'h0000, 1'b0);
		xfer(8'h00, 16'h0000, 1'b0);
		for (int m = 3; m >= 0; m--) xfer(8'hFB, m, 1'b0);
		xfer(8'hFA, 16'h0106, 1'b0);
		xfer(8'hFA, 16'h0006, 1'b0);
		xfer(8'hF3, 16'h0037, 1'b0);
		xfer(8'h73, 16'h0000, 1'b0);
		xfer(8'hFB, 16'h0002, 1'b1);
		// a second request inside the two busy cycles is ignored
		host.send(8'hFB, 16'h0002, 1'b0);
		host.send(8'hFB, 16'h0001, 1'b0);
		#1;
		check(rsp_valid_q, 1'b1);
		m_mode = 16'h0002;
		repeat (4) begin
			@(posedge core_clk);
			#1;
			check(rsp_valid_q, 1'b0);
		end
		check(op_mode_q, m_mode);
		for (int i = 0; i < 40; i++) xfer(codes[rnd() % 18], rnd(), 1'b0);
		ext_rst <= 1'b1;
		repeat (4) @(posedge core_clk);
		ext_rst <= 1'b0;
		#1;
		check({oe, trip}, 2'b10);
		stop_test();
	end
endmodule // tb
`default_nettype wire
